// ---- core/hetc_pkg.sv ----
// Constants for the low half of the hybrid echo tap coefficient store.
// Assumes register numbers arrive as 8-bit indices on the control port.
package hetc_pkg;
    localparam int COEFF_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int NUM_TAPS = 8;
    localparam int LOW_TAPS = 4;
    localparam int ADDR_W = 8;
    localparam int COEFF_FRAC = 7;
    localparam logic [ADDR_W-1:0] REG_TAP1_IDX = 8'h2d;
    localparam logic [ADDR_W-1:0] REG_TAP2_IDX = 8'h2e;
    localparam logic [ADDR_W-1:0] REG_TAP3_IDX = 8'h2f;
    localparam logic [ADDR_W-1:0] REG_TAP4_IDX = 8'h30;
    localparam logic [ADDR_W-1:0] REG_TAP5_IDX = 8'h31;
    localparam logic [COEFF_W-1:0] COEFF_RESET = 8'h00;
    localparam logic [COEFF_W-1:0] UNMAPPED_READ = 8'h00;
endpackage

// ---- core/hetc_tap.sv ----
// One filter stage: a transmit sample weighted by its tap coefficient.
// Assumes both inputs are signed two's complement on the same clock.
`timescale 1ns/10ps
`default_nettype none
module hetc_tap #(
    parameter int SAMPLE_W = hetc_pkg::SAMPLE_W,
    parameter int COEFF_W = hetc_pkg::COEFF_W
) (
    // Operands
    input wire logic signed [SAMPLE_W-1:0] sample,
    input wire logic signed [COEFF_W-1:0] coeff,
    // Weighted sample
    output logic signed [SAMPLE_W+COEFF_W-1:0] product
);
    wire coeff_zero = (coeff == '0);
    wire signed [SAMPLE_W+COEFF_W-1:0] full_product = sample * coeff;

    // A cleared coefficient takes the stage out of the response.
    assign product = coeff_zero ? '0 : full_product; // RULE5
endmodule
`default_nettype wire

// ---- core/hetc_top.sv ----
// Coefficient registers for taps one to four and the eight-tap echo filter that uses them.
// Assumes the control port, the sample strobe and taps five to eight share clk.
//
// How it works
// RULE1: Register 0x2d holds a read/write 8-bit coefficient used as tap one.
// RULE2: Register 0x2e holds a read/write 8-bit coefficient used as tap two.
// RULE3: Register 0x2f holds a read/write 8-bit coefficient used as tap three.
// RULE4: Register 0x30 holds a read/write 8-bit coefficient used as tap four.
// RULE5: A zero coefficient makes its filter stage contribute nothing.
// RULE6: The weighted transmit history is removed from receive to cut near-end echo.
// RULE7: Taps five to eight come from registers starting at 0x31, same 8-bit behaviour.
// RULE8: Output is receive minus sum of last eight transmit samples times coefficients.
`timescale 1ns/10ps
`default_nettype none
module hetc_top #(
    parameter int SAMPLE_W = hetc_pkg::SAMPLE_W,
    parameter int COEFF_FRAC = hetc_pkg::COEFF_FRAC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,

    // Control register port
    input wire logic [hetc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hetc_pkg::COEFF_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hetc_pkg::COEFF_W-1:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_hit,

    // Coefficients of the upper taps, held elsewhere
    input wire logic [hetc_pkg::COEFF_W-1:0] echo_tap5_coeff,
    input wire logic [hetc_pkg::COEFF_W-1:0] echo_tap6_coeff,
    input wire logic [hetc_pkg::COEFF_W-1:0] echo_tap7_coeff,
    input wire logic [hetc_pkg::COEFF_W-1:0] echo_tap8_coeff,

    // Sample path
    input wire logic sample_stb,
    input wire logic signed [SAMPLE_W-1:0] tx_sample,
    input wire logic signed [SAMPLE_W-1:0] rx_sample,
    output logic signed [SAMPLE_W-1:0] rx_out,
    output logic rx_out_valid,

    // Coefficients of the lower taps
    output logic [hetc_pkg::COEFF_W-1:0] echo_tap1_coeff,
    output logic [hetc_pkg::COEFF_W-1:0] echo_tap2_coeff,
    output logic [hetc_pkg::COEFF_W-1:0] echo_tap3_coeff,
    output logic [hetc_pkg::COEFF_W-1:0] echo_tap4_coeff
);
    localparam int CW = hetc_pkg::COEFF_W;
    localparam int NT = hetc_pkg::NUM_TAPS;
    localparam int LT = hetc_pkg::LOW_TAPS;
    localparam int PROD_W = SAMPLE_W + CW;
    localparam int ACC_W = PROD_W + $clog2(NT);
    localparam logic signed [ACC_W:0] SAT_MAX = (ACC_W+1)'((2 ** (SAMPLE_W - 1)) - 1);
    localparam logic signed [ACC_W:0] SAT_MIN = -SAT_MAX - (ACC_W+1)'(1);

    // Maps a register number onto a one-hot select of the lower taps.
    function automatic logic [LT-1:0] hetc_decode(input logic [hetc_pkg::ADDR_W-1:0] a);
        logic [LT-1:0] sel;
        sel = '0;
        sel[0] = (a == hetc_pkg::REG_TAP1_IDX);
        sel[1] = (a == hetc_pkg::REG_TAP2_IDX);
        sel[2] = (a == hetc_pkg::REG_TAP3_IDX);
        sel[3] = (a == hetc_pkg::REG_TAP4_IDX);
        return sel;
    endfunction

    // Register file.
    logic [CW-1:0] coeff_r [LT];
    wire [LT-1:0] wr_sel = reg_wr ? hetc_decode(reg_addr) : '0;
    wire [LT-1:0] rd_sel = hetc_decode(reg_addr);
    wire rd_hit = |rd_sel;

    genvar g;
    generate
        for (g = 0; g < LT; g++) begin : g_coeff
            // Each coefficient register is written whole and reads back unchanged.
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    coeff_r[g] <= hetc_pkg::COEFF_RESET;
                end else if (wr_sel[g]) begin
                    coeff_r[g] <= reg_wdata; // RULE1 RULE2 RULE3 RULE4
                end
            end
        end
    endgenerate

    assign echo_tap1_coeff = coeff_r[0]; // RULE1
    assign echo_tap2_coeff = coeff_r[1]; // RULE2
    assign echo_tap3_coeff = coeff_r[2]; // RULE3
    assign echo_tap4_coeff = coeff_r[3]; // RULE4

    // Read path: one cycle after the request, unmapped numbers return zero.
    logic [CW-1:0] rdata_nxt;
    always_comb begin
        rdata_nxt = hetc_pkg::UNMAPPED_READ;
        for (int i = 0; i < LT; i++) begin
            if (rd_sel[i]) begin
                rdata_nxt = coeff_r[i];
            end
        end
    end

    logic [CW-1:0] reg_rdata_r;
    logic reg_rd_valid_r;
    logic reg_hit_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_r <= hetc_pkg::UNMAPPED_READ;
            reg_rd_valid_r <= 1'b0;
            reg_hit_r <= 1'b0;
        end else begin
            reg_rd_valid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rdata_nxt;
                reg_hit_r <= rd_hit;
            end
        end
    end
    assign reg_rdata = reg_rdata_r;
    assign reg_rd_valid = reg_rd_valid_r;
    assign reg_hit = reg_hit_r;

    // All eight coefficients, lower taps local and upper taps from outside.
    wire [CW-1:0] tap_coeff [NT];
    generate
        for (g = 0; g < LT; g++) begin : g_low
            assign tap_coeff[g] = coeff_r[g];
        end
    endgenerate
    wire [CW-1:0] upper_coeff [NT-LT];
    assign upper_coeff[0] = echo_tap5_coeff; // RULE7
    assign upper_coeff[1] = echo_tap6_coeff; // RULE7
    assign upper_coeff[2] = echo_tap7_coeff; // RULE7
    assign upper_coeff[3] = echo_tap8_coeff; // RULE7
    generate
        for (g = LT; g < NT; g++) begin : g_high
            assign tap_coeff[g] = upper_coeff[g-LT];
        end
    endgenerate

    // Transmit history line; entry zero is the newest sample.
    logic signed [SAMPLE_W-1:0] hist_r [NT];
    logic signed [SAMPLE_W-1:0] rx_hold_r;
    logic calc_r;

    // Each strobe moves the history one place and puts the new sample in front.
    wire signed [SAMPLE_W-1:0] hist_nxt [NT];
    assign hist_nxt[0] = tx_sample; // RULE8
    generate
        for (g = 1; g < NT; g++) begin : g_shift
            assign hist_nxt[g] = hist_r[g-1];
        end
    endgenerate
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NT; i++) begin
                hist_r[i] <= '0;
            end
            rx_hold_r <= '0;
            calc_r <= 1'b0;
        end else begin
            calc_r <= sample_stb;
            if (sample_stb) begin
                for (int i = 0; i < NT; i++) begin
                    hist_r[i] <= hist_nxt[i];
                end
                rx_hold_r <= rx_sample;
            end
        end
    end

    // Filter stages.
    wire signed [PROD_W-1:0] prod [NT];
    generate
        for (g = 0; g < NT; g++) begin : g_tap
            hetc_tap #(
                .SAMPLE_W(SAMPLE_W),
                .COEFF_W(CW)
            ) u_tap (
                .sample(hist_r[g]),
                .coeff(tap_coeff[g]),
                .product(prod[g])
            );
        end
    endgenerate

    // Echo estimate and its removal from the receive sample.
    logic signed [ACC_W-1:0] acc;
    always_comb begin
        acc = '0;
        for (int i = 0; i < NT; i++) begin
            acc = acc + ACC_W'(prod[i]); // RULE8
        end
    end
    wire signed [ACC_W-1:0] echo_est = acc >>> COEFF_FRAC;
    wire signed [ACC_W:0] diff = (ACC_W+1)'(rx_hold_r) - (ACC_W+1)'(echo_est); // RULE6
    // Clipping keeps a large echo estimate from wrapping the receive sample.
    wire sat_hi = (diff > SAT_MAX);
    wire sat_lo = (diff < SAT_MIN);
    wire signed [SAMPLE_W-1:0] rx_nxt = sat_hi ? SAT_MAX[SAMPLE_W-1:0] :
                                        sat_lo ? SAT_MIN[SAMPLE_W-1:0] :
                                        diff[SAMPLE_W-1:0];

    // The result register loads one cycle after each strobe and holds that result until the next such load replaces it.
    logic signed [SAMPLE_W-1:0] rx_out_r;
    logic rx_out_valid_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_out_r <= '0;
            rx_out_valid_r <= 1'b0;
        end else begin
            rx_out_valid_r <= calc_r;
            if (calc_r) begin
                rx_out_r <= rx_nxt; // RULE6
            end
        end
    end
    assign rx_out = rx_out_r;
    assign rx_out_valid = rx_out_valid_r;
endmodule
`default_nettype wire

// ---- test/hetc_top_properties.sv ----
// Checker for the low hybrid echo tap store and its filter timing.
// Assumes it is bound into hetc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module hetc_top_properties #(
    parameter int SAMPLE_W = hetc_pkg::SAMPLE_W
) (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic reg_hit,
    // Coefficients and sample path
    input wire logic [7:0] echo_tap1_coeff,
    input wire logic [7:0] echo_tap2_coeff,
    input wire logic [7:0] echo_tap3_coeff,
    input wire logic [7:0] echo_tap4_coeff,
    input wire logic [7:0] echo_tap5_coeff,
    input wire logic [7:0] echo_tap6_coeff,
    input wire logic [7:0] echo_tap7_coeff,
    input wire logic [7:0] echo_tap8_coeff,
    input wire logic sample_stb,
    input wire logic signed [SAMPLE_W-1:0] rx_sample,
    input wire logic signed [SAMPLE_W-1:0] rx_out,
    input wire logic rx_out_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic hit = reg_addr >= 8'h2d && reg_addr <= 8'h30;
    wire logic [7:0] lo = echo_tap1_coeff | echo_tap2_coeff | echo_tap3_coeff | echo_tap4_coeff;
    wire logic [7:0] hi = echo_tap5_coeff | echo_tap6_coeff | echo_tap7_coeff | echo_tap8_coeff;
    sequence s_zero_in;
        sample_stb ##1 (lo | hi) == 8'h00;
    endsequence
    chk_tap1_write: assert property (reg_wr && reg_addr == 8'h2d |=> echo_tap1_coeff == $past(reg_wdata))
        else $error("tap one write lost");
    chk_tap2_write: assert property (reg_wr && reg_addr == 8'h2e |=> echo_tap2_coeff == $past(reg_wdata))
        else $error("tap two write lost");
    chk_tap3_write: assert property (reg_wr && reg_addr == 8'h2f |=> echo_tap3_coeff == $past(reg_wdata))
        else $error("tap three write lost");
    chk_tap4_write: assert property (reg_wr && reg_addr == 8'h30 |=> echo_tap4_coeff == $past(reg_wdata))
        else $error("tap four write lost");
    chk_coeff_hold: assert property (!(reg_wr && hit) |=>
        $stable({echo_tap1_coeff, echo_tap2_coeff, echo_tap3_coeff, echo_tap4_coeff}))
        else $error("coefficient changed without write");
    chk_read_valid: assert property (reg_rd |=> reg_rd_valid ##1 !reg_rd_valid || $past(reg_rd))
        else $error("read valid timing wrong");
    chk_tap2_read: assert property (reg_rd && reg_addr == 8'h2e |=> reg_hit && reg_rdata == $past(echo_tap2_coeff))
        else $error("tap two read wrong");
    chk_unmapped_read: assert property (reg_rd && !hit |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read wrong");
    chk_zero_pass: assert property (s_zero_in |=> rx_out_valid && rx_out == $past(rx_sample, 2))
        else $error("zero taps altered receive");
    chk_out_valid: assert property (sample_stb |-> ##2 rx_out_valid)
        else $error("result valid late");
    chk_out_pulse: assert property (!sample_stb |-> ##2 !rx_out_valid)
        else $error("result valid without strobe");
endmodule
bind hetc_top hetc_top_properties #(.SAMPLE_W(SAMPLE_W)) u_props (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .reg_hit(reg_hit), .echo_tap1_coeff(echo_tap1_coeff), .echo_tap2_coeff(echo_tap2_coeff),
    .echo_tap3_coeff(echo_tap3_coeff), .echo_tap4_coeff(echo_tap4_coeff),
    .echo_tap5_coeff(echo_tap5_coeff), .echo_tap6_coeff(echo_tap6_coeff),
    .echo_tap7_coeff(echo_tap7_coeff), .echo_tap8_coeff(echo_tap8_coeff),
    .sample_stb(sample_stb), .rx_sample(rx_sample), .rx_out(rx_out),
    .rx_out_valid(rx_out_valid)
);
`default_nettype wire

// ---- test/hetc_top_bench.sv ----
// Testbench for the low hybrid echo tap store and the filter using it.
// Assumes hetc_top with its bound checker; every input is driven here.
`timescale 1ns/10ps
`default_nettype none
module hetc_top_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wr = 1'b0, rd = 1'b0, stb = 1'b0, rv, hit, ov;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat, t1, t2, t3, t4;
    logic [7:0] cf [1:8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] txs = 16'h0000, rxs = 16'h0000, ro;
    int hist [8] = '{0, 0, 0, 0, 0, 0, 0, 0};
    int n_errors = 0, checks = 0;
    hetc_top DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdat), .reg_rd_valid(rv), .reg_hit(hit), .echo_tap5_coeff(cf[5]),
        .echo_tap6_coeff(cf[6]), .echo_tap7_coeff(cf[7]), .echo_tap8_coeff(cf[8]),
        .sample_stb(stb), .tx_sample(txs), .rx_sample(rxs), .rx_out(ro), .rx_out_valid(ov),
        .echo_tap1_coeff(t1), .echo_tap2_coeff(t2), .echo_tap3_coeff(t3), .echo_tap4_coeff(t4));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        if (a >= 8'h2d && a <= 8'h30) cf[a - 8'h2c] = d;
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp(rv, 16'h0001);
        cmp(rdat, e);
        cmp(hit, h);
    endtask
    task automatic smp(input int tx, input int rx);
        int acc;
        for (int i = 7; i > 0; i--) hist[i] = hist[i-1];
        hist[0] = tx;
        acc = 0;
        for (int i = 0; i < 8; i++) acc += hist[i] * $signed(cf[i+1]);
        acc = rx - (acc >>> 7);
        if (acc > 32767) acc = 32767;
        if (acc < -32768) acc = -32768;
        @(posedge clk);
        stb <= 1'b1;
        txs <= tx[15:0];
        rxs <= rx[15:0];
        @(posedge clk);
        stb <= 1'b0;
        @(posedge clk);
        #1;
        cmp(ov, 16'h0001);
        cmp(ro, acc[15:0]);
        @(posedge clk);
        #1;
        cmp(ov, 16'h0000);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 4; i++) rdr(8'(8'h2d + i), 8'h00, 1'b1);
        $display("t_reset done");
    endtask
    task automatic t_regs;
        wrr(8'h2d, 8'h80);
        wrr(8'h2e, 8'h7f);
        wrr(8'h2f, 8'hff);
        wrr(8'h30, 8'h01);
        wrr(8'h31, 8'h55);
        wrr(8'h2c, 8'haa);
        #1;
        cmp({t1, t2}, 16'h807f);
        cmp({t3, t4}, 16'hff01);
        for (int i = 1; i < 5; i++) rdr(8'(8'h2c + i), cf[i], 1'b1);
        rdr(8'h31, 8'h00, 1'b0);
        rdr(8'h2c, 8'h00, 1'b0);
        $display("t_regs done");
    endtask
    task automatic t_filter;
        @(posedge clk);
        cf[5] <= 8'h10;
        cf[6] <= 8'hf0;
        cf[7] <= 8'h00;
        cf[8] <= 8'h7f;
        wrr(8'h2d, 8'h40);
        wrr(8'h2e, 8'h00);
        for (int i = 0; i < 10; i++) smp(i * 7001 - 32768, 32767 - i * 6500);
        $display("t_filter done");
    endtask
    task automatic t_zero;
        @(posedge clk);
        cf[5] <= 8'h00;
        cf[6] <= 8'h00;
        cf[8] <= 8'h00;
        for (int i = 0; i < 4; i++) wrr(8'(8'h2d + i), 8'h00);
        for (int i = 0; i < 3; i++) smp(30000 - i * 9000, i * 1000 - 1234);
        $display("t_zero done");
    endtask
    task automatic end_sim;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_filter();
        t_zero();
        end_sim();
    end
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
